/* File: tmpc_consts.svh */
`ifndef TMPC_CONSTS_SVH
`define TMPC_CONSTS_SVH

`define TMPC_POS_W         7
`define TMPC_POS_MIN       7'h00
`define TMPC_POS_MAX       7'h63
`define TMPC_PRESET_COUNT  10
`define TMPC_CODE_W        4
`define TMPC_CODE_FULL     4'hA
`define TMPC_CODE_HOLD_LAST_POSITION_PRESET     4'hB
`define TMPC_CODE_LAST_STD 4'h9
`define TMPC_RST_PRESET    4'h0
`define TMPC_RST_POS       7'h00
`define TMPC_RST_ADDR      4'h0

`endif

/* File: tmpc_pkg.sv */
`include "tmpc_consts.svh"

package tmpc_pkg;

    typedef logic [`TMPC_POS_W-1:0]  tmpc_pos_t;
    typedef logic [`TMPC_CODE_W-1:0] tmpc_code_t;

    typedef enum logic [1:0] {
        TMPC_MODE_LOCAL    = 2'b00,
        TMPC_MODE_REM_AUTO = 2'b01,
        TMPC_MODE_REM_MAN  = 2'b10,
        TMPC_MODE_AUTO_CTL = 2'b11
    } tmpc_mode_e;

    typedef enum logic [1:0] {
        TMPC_SEL_STD     = 2'b00,
        TMPC_SEL_FULL    = 2'b01,
        TMPC_SEL_HOLD_LAST_POSITION_PRESET    = 2'b10,
        TMPC_SEL_INVALID = 2'b11
    } tmpc_sel_e;

    typedef struct packed {
        tmpc_pos_t c1;
        tmpc_pos_t c2;
    } tmpc_pair_s;

    typedef struct packed {
        logic                                remote;
        tmpc_mode_e                          mode;
        tmpc_code_t                          entry_preset;
        logic                                rf_prev;
        logic                                tune_start;
        logic                                tune_active;
        logic                                preset_invalid;
        tmpc_pair_s                          goal;
        tmpc_pair_s                          last;
        tmpc_pair_s                          report;
        logic                                goal_en;
        tmpc_code_t                          bus_addr;
        logic                                bus_addr_valid;
        logic                                pwr_mon_oe_n;
        tmpc_pair_s [`TMPC_PRESET_COUNT-1:0] presets;
    } tmpc_state_s;

    typedef struct packed {
        logic up;
        logic dn;
        logic at_goal;
    } tmpc_mover_s;

endpackage : tmpc_pkg

/* File: tmpc_cap_mover.sv */
`timescale 1ns/1ps
`include "tmpc_consts.svh"

module tmpc_cap_mover #(
    parameter int POS_W = `TMPC_POS_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             enable,
    input  wire logic [POS_W-1:0] goal,
    input  wire logic [POS_W-1:0] position,
    output logic                  motor_up_q,
    output logic                  motor_dn_q,
    output logic                  at_goal_q
);

    tmpc_pkg::tmpc_mover_s s_q;
    tmpc_pkg::tmpc_mover_s s_d;

    // never both directions at once: a shorted bridge would burn the drive
    always_comb begin
        s_d.up      = enable && (position < goal);
        s_d.dn      = enable && (position > goal);
        s_d.at_goal = (position == goal);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign motor_up_q = s_q.up;
    assign motor_dn_q = s_q.dn;
    assign at_goal_q  = s_q.at_goal;

endmodule : tmpc_cap_mover

/* File: tmpc_top.sv */
`timescale 1ns/1ps
`include "tmpc_consts.svh"

// Notes on behaviour
// - analog inputs used only in remote mode
// - open select gives auto, grounded gives manual
// - auto mode starts tuning on RF detect
// - remote auto starts from preset chosen before entry
// - manual set-points position capacitors proportionally
// - capacitor positions reported continuously on outputs
// - open-collector power monitor active while powered
// - switch twelve on selects automatic control
// - automatic control locks auto-tune, tunes on RF
// - RF removal moves capacitors to start point
// - start point presets 0-9, full or hold
// - switches 1-4 address, or preset under twelve
// - full-mesh preset starts both at maximum
// - hold preset starts where RF last removed
module tmpc_top #(
    parameter int POS_W        = `TMPC_POS_W,
    parameter int PRESET_COUNT = `TMPC_PRESET_COUNT
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    local_remote_button,
    input  wire logic                    remote_mode_command,
    input  wire logic                    tune_select_open,
    input  wire logic                    config_switch_12,
    input  wire logic [3:0]              config_switches_1_4,
    input  wire logic [3:0]              panel_preset_select,
    input  wire logic                    rf_detected,
    input  wire logic                    tune_done,
    input  wire logic [POS_W-1:0]        first_tuning_capacitor_setpoint,
    input  wire logic [POS_W-1:0]        second_tuning_capacitor_setpoint,
    input  wire logic [POS_W-1:0]        first_tuning_capacitor_position,
    input  wire logic [POS_W-1:0]        second_tuning_capacitor_position,
    input  wire logic                    preset_write,
    input  wire logic [3:0]              preset_write_index,
    input  wire logic [POS_W-1:0]        preset_write_c1,
    input  wire logic [POS_W-1:0]        preset_write_c2,
    output logic                         remote_active_q,
    output tmpc_pkg::tmpc_mode_e         mode_q,
    output logic                         tune_start_q,
    output logic                         tune_active_q,
    output logic                         preset_invalid_q,
    output logic [POS_W-1:0]             first_tuning_capacitor_report_q,
    output logic [POS_W-1:0]             second_tuning_capacitor_report_q,
    output logic [POS_W-1:0]             first_tuning_capacitor_goal_q,
    output logic [POS_W-1:0]             second_tuning_capacitor_goal_q,
    output logic                         first_tuning_capacitor_up_q,
    output logic                         first_tuning_capacitor_dn_q,
    output logic                         second_tuning_capacitor_up_q,
    output logic                         second_tuning_capacitor_dn_q,
    output logic                         capacitors_at_goal_q,
    output logic [3:0]                   bus_address_q,
    output logic                         bus_address_valid_q,
    output logic                         power_on_monitor_o_q,
    output logic                         power_on_monitor_oe_n_q
);

    tmpc_pkg::tmpc_state_s s_q;
    tmpc_pkg::tmpc_state_s s_d;

    function automatic tmpc_pkg::tmpc_sel_e decode_preset(input tmpc_pkg::tmpc_code_t code);
        if (code <= `TMPC_CODE_LAST_STD) begin
            decode_preset = tmpc_pkg::TMPC_SEL_STD;
        end else if (code == `TMPC_CODE_FULL) begin
            decode_preset = tmpc_pkg::TMPC_SEL_FULL;
        end else if (code == `TMPC_CODE_HOLD_LAST_POSITION_PRESET) begin
            decode_preset = tmpc_pkg::TMPC_SEL_HOLD_LAST_POSITION_PRESET;
        end else begin
            decode_preset = tmpc_pkg::TMPC_SEL_INVALID;
        end
    endfunction : decode_preset

    tmpc_pkg::tmpc_code_t  start_code;
    tmpc_pkg::tmpc_sel_e   start_sel;
    tmpc_pkg::tmpc_pair_s  start_pos;
    tmpc_pkg::tmpc_pair_s  feedback;
    tmpc_pkg::tmpc_mode_e  mode_next;
    logic                  auto_mode;
    logic                  rf_rise;
    logic                  rf_fall;
    logic [1:0]            at_goal;
    logic [1:0]            motor_up;
    logic [1:0]            motor_dn;

    always_comb begin
        s_d      = s_q;
        feedback = '{c1: first_tuning_capacitor_position, c2: second_tuning_capacitor_position};
        rf_rise  = rf_detected && !s_q.rf_prev;
        rf_fall  = !rf_detected && s_q.rf_prev;

        // button toggles, command only enters; both together enter
        if (remote_mode_command) begin
            s_d.remote = 1'b1;
        end else if (local_remote_button) begin
            s_d.remote = !s_q.remote;
        end
        if ((remote_mode_command || local_remote_button) && !s_q.remote) begin
            s_d.entry_preset = panel_preset_select;
        end

        if (config_switch_12) begin
            mode_next = tmpc_pkg::TMPC_MODE_AUTO_CTL;
        end else if (!s_q.remote) begin
            mode_next = tmpc_pkg::TMPC_MODE_LOCAL;
        end else if (tune_select_open) begin
            mode_next = tmpc_pkg::TMPC_MODE_REM_AUTO;
        end else begin
            mode_next = tmpc_pkg::TMPC_MODE_REM_MAN;
        end
        s_d.mode = mode_next;
        auto_mode = (mode_next == tmpc_pkg::TMPC_MODE_AUTO_CTL) ||
                    (mode_next == tmpc_pkg::TMPC_MODE_REM_AUTO);

        // switches repurposed only under automatic control
        s_d.bus_addr       = config_switch_12 ? `TMPC_RST_ADDR : config_switches_1_4;
        s_d.bus_addr_valid = !config_switch_12;
        start_code = config_switch_12 ? config_switches_1_4 : s_q.entry_preset;
        start_sel  = decode_preset(start_code);

        unique case (start_sel)
            tmpc_pkg::TMPC_SEL_STD: begin
                start_pos = s_q.presets[start_code];
            end
            tmpc_pkg::TMPC_SEL_FULL: begin
                start_pos = '{c1: `TMPC_POS_MAX, c2: `TMPC_POS_MAX};
            end
            tmpc_pkg::TMPC_SEL_HOLD_LAST_POSITION_PRESET: begin
                // on the drop edge the snapshot is not registered yet; stale value would jerk the motors
                start_pos = rf_fall ? feedback : s_q.last;
            end
            tmpc_pkg::TMPC_SEL_INVALID: begin
                start_pos = feedback;
            end
        endcase
        s_d.preset_invalid = auto_mode && (start_sel == tmpc_pkg::TMPC_SEL_INVALID);

        // snapshot taken on the RF drop feeds the hold preset
        if (rf_fall) begin
            s_d.last = feedback;
        end
        s_d.rf_prev = rf_detected;

        s_d.tune_start = auto_mode && rf_rise;
        // a fresh RF edge outranks a done left over from the previous tune
        if (auto_mode && rf_rise) begin
            s_d.tune_active = 1'b1;
        end else if (!auto_mode || !rf_detected || tune_done) begin
            s_d.tune_active = 1'b0;
        end

        // the tuning engine owns the motors while RF is on in auto
        unique case (mode_next)
            tmpc_pkg::TMPC_MODE_LOCAL: begin
                s_d.goal    = feedback;
                s_d.goal_en = 1'b0;
            end
            tmpc_pkg::TMPC_MODE_REM_MAN: begin
                s_d.goal.c1 = (first_tuning_capacitor_setpoint > `TMPC_POS_MAX) ?
                              `TMPC_POS_MAX : first_tuning_capacitor_setpoint;
                s_d.goal.c2 = (second_tuning_capacitor_setpoint > `TMPC_POS_MAX) ?
                              `TMPC_POS_MAX : second_tuning_capacitor_setpoint;
                s_d.goal_en = 1'b1;
            end
            tmpc_pkg::TMPC_MODE_REM_AUTO, tmpc_pkg::TMPC_MODE_AUTO_CTL: begin
                s_d.goal    = start_pos;
                s_d.goal_en = !rf_detected && (start_sel != tmpc_pkg::TMPC_SEL_INVALID);
            end
        endcase

        s_d.report       = feedback;
        s_d.pwr_mon_oe_n = 1'b0;

        if (preset_write && (preset_write_index < 4'(PRESET_COUNT))) begin
            s_d.presets[preset_write_index] = '{c1: preset_write_c1, c2: preset_write_c2};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q              <= '0;
            s_q.mode         <= tmpc_pkg::TMPC_MODE_LOCAL;
            s_q.entry_preset <= `TMPC_RST_PRESET;
            s_q.pwr_mon_oe_n <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_mover
            tmpc_cap_mover #(
                .POS_W(POS_W)
            ) u_mover (
                .clk       (clk),
                .reset_n   (reset_n),
                .enable    (s_q.goal_en),
                .goal      ((i == 0) ? s_q.goal.c1 : s_q.goal.c2),
                .position  ((i == 0) ? feedback.c1 : feedback.c2),
                .motor_up_q(motor_up[i]),
                .motor_dn_q(motor_dn[i]),
                .at_goal_q (at_goal[i])
            );
        end
    endgenerate

    assign remote_active_q                  = s_q.remote;
    assign mode_q                           = s_q.mode;
    assign tune_start_q                     = s_q.tune_start;
    assign tune_active_q                    = s_q.tune_active;
    assign preset_invalid_q                 = s_q.preset_invalid;
    assign first_tuning_capacitor_report_q  = s_q.report.c1;
    assign second_tuning_capacitor_report_q = s_q.report.c2;
    assign first_tuning_capacitor_goal_q    = s_q.goal.c1;
    assign second_tuning_capacitor_goal_q   = s_q.goal.c2;
    assign first_tuning_capacitor_up_q      = motor_up[0];
    assign first_tuning_capacitor_dn_q      = motor_dn[0];
    assign second_tuning_capacitor_up_q     = motor_up[1];
    assign second_tuning_capacitor_dn_q     = motor_dn[1];
    assign capacitors_at_goal_q             = at_goal[0] & at_goal[1];
    assign bus_address_q                    = s_q.bus_addr;
    assign bus_address_valid_q              = s_q.bus_addr_valid;
    // open collector: pin pulled low whenever powered, during reset as well as out of it
    assign power_on_monitor_o_q             = 1'b0;
    assign power_on_monitor_oe_n_q          = s_q.pwr_mon_oe_n;

endmodule : tmpc_top

/* File: tmpc_top_checker.sv */
`timescale 1ns/1ps
module tmpc_top_checker #(
    parameter int POS_W = 7
) (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 local_remote_button,
    input wire logic                 remote_mode_command,
    input wire logic                 tune_select_open,
    input wire logic                 config_switch_12,
    input wire logic [3:0]           config_switches_1_4,
    input wire logic                 rf_detected,
    input wire logic [POS_W-1:0]     first_tuning_capacitor_setpoint,
    input wire logic [POS_W-1:0]     first_tuning_capacitor_position,
    input wire logic                 remote_active_q,
    input wire tmpc_pkg::tmpc_mode_e mode_q,
    input wire logic                 tune_start_q,
    input wire logic                 preset_invalid_q,
    input wire logic [POS_W-1:0]     first_tuning_capacitor_report_q,
    input wire logic [POS_W-1:0]     first_tuning_capacitor_goal_q,
    input wire logic [POS_W-1:0]     second_tuning_capacitor_goal_q,
    input wire logic [3:0]           bus_address_q,
    input wire logic                 bus_address_valid_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_full_idle;
        config_switch_12 && config_switches_1_4 == 4'hA && !rf_detected;
    endsequence
    sequence s_bad_code;
        config_switch_12 && config_switches_1_4 >= 4'hC;
    endsequence

    a_local_idle: assert property (mode_q == tmpc_pkg::TMPC_MODE_LOCAL && !remote_active_q
        && !local_remote_button
        && !remote_mode_command && !config_switch_12
        |=> first_tuning_capacitor_goal_q == $past(first_tuning_capacitor_position))
        else $error("local mode goal not holding feedback");
    a_manual_no_start: assert property (mode_q == tmpc_pkg::TMPC_MODE_REM_MAN
        && $past(mode_q) == tmpc_pkg::TMPC_MODE_REM_MAN |-> !tune_start_q)
        else $error("tuning started in manual mode");
    a_start_pulse: assert property (tune_start_q |-> $past(rf_detected) ##1 !tune_start_q)
        else $error("tune start without rf or too long");
    a_manual_goal: assert property (mode_q == tmpc_pkg::TMPC_MODE_REM_MAN && !tune_select_open
        && remote_active_q
        && !config_switch_12 && !local_remote_button
        |=> first_tuning_capacitor_goal_q == ($past(first_tuning_capacitor_setpoint) > 7'h63
            ? 7'h63 : $past(first_tuning_capacitor_setpoint)))
        else $error("manual goal does not follow set-point");
    a_report_follow: assert property ($past(reset_n)
        |-> first_tuning_capacitor_report_q == $past(first_tuning_capacitor_position))
        else $error("position report not following feedback");
    a_auto_lock: assert property (config_switch_12 |=> mode_q == tmpc_pkg::TMPC_MODE_AUTO_CTL)
        else $error("switch twelve did not lock automatic control");
    a_full_goal: assert property (s_full_idle ##1 s_full_idle
        |=> first_tuning_capacitor_goal_q == 7'h63 && second_tuning_capacitor_goal_q == 7'h63)
        else $error("full mesh start point not applied");
    a_bad_code: assert property (s_bad_code ##1 s_bad_code |=> preset_invalid_q)
        else $error("invalid start code not flagged");
    a_addr_pass: assert property (!config_switch_12
        |=> bus_address_q == $past(config_switches_1_4) && bus_address_valid_q)
        else $error("bus address not taken from switches");
    a_addr_hide: assert property (config_switch_12 |=> bus_address_q == 4'h0 && !bus_address_valid_q)
        else $error("bus address still valid in automatic control");
endmodule : tmpc_top_checker

bind tmpc_top tmpc_top_checker #(.POS_W(POS_W)) u_chk (.*);

/* File: tmpc_mech_model.sv */
`timescale 1ns/1ps
module tmpc_mech_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       first_tuning_capacitor_up_q,
    input  wire logic       first_tuning_capacitor_dn_q,
    input  wire logic       second_tuning_capacitor_up_q,
    input  wire logic       second_tuning_capacitor_dn_q,
    output logic [6:0]      first_tuning_capacitor_position,
    output logic [6:0]      second_tuning_capacitor_position
);
    logic [1:0] div_q;

    // one step every fourth cycle: a slow drive hides any overshoot from the mover's one-cycle lag
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            first_tuning_capacitor_position  <= 7'h00;
            second_tuning_capacitor_position <= 7'h00;
            div_q                            <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h0) begin
                // end stops: 0 fully unmeshed, 99 fully meshed
                if (first_tuning_capacitor_up_q && first_tuning_capacitor_position < 7'h63) begin
                    first_tuning_capacitor_position <= first_tuning_capacitor_position + 7'h01;
                end else if (first_tuning_capacitor_dn_q && first_tuning_capacitor_position != 7'h00) begin
                    first_tuning_capacitor_position <= first_tuning_capacitor_position - 7'h01;
                end
                if (second_tuning_capacitor_up_q && second_tuning_capacitor_position < 7'h63) begin
                    second_tuning_capacitor_position <= second_tuning_capacitor_position + 7'h01;
                end else if (second_tuning_capacitor_dn_q && second_tuning_capacitor_position != 7'h00) begin
                    second_tuning_capacitor_position <= second_tuning_capacitor_position - 7'h01;
                end
            end
        end
    end
endmodule : tmpc_mech_model

/* File: tmpc_top_tb_top.sv */
`timescale 1ns/1ps
module tmpc_top_tb_top;
    logic       clk = 1'b0, reset_n = 1'b0, local_remote_button = 1'b0, remote_mode_command = 1'b0;
    logic       tune_select_open = 1'b1, config_switch_12 = 1'b0, rf_detected = 1'b0, tune_done = 1'b0;
    logic       preset_write = 1'b0;
    logic [3:0] config_switches_1_4 = 4'h5, panel_preset_select = 4'h0, preset_write_index = 4'h0;
    logic [6:0] first_tuning_capacitor_setpoint = 7'h00, second_tuning_capacitor_setpoint = 7'h00;
    logic [6:0] preset_write_c1 = 7'h00, preset_write_c2 = 7'h00;
    logic [6:0] first_tuning_capacitor_position, second_tuning_capacitor_position;
    logic [6:0] first_tuning_capacitor_report_q, second_tuning_capacitor_report_q;
    logic [6:0] first_tuning_capacitor_goal_q, second_tuning_capacitor_goal_q;
    logic [3:0] bus_address_q;
    logic       remote_active_q, tune_start_q, tune_active_q, preset_invalid_q, capacitors_at_goal_q;
    logic       first_tuning_capacitor_up_q, first_tuning_capacitor_dn_q;
    logic       second_tuning_capacitor_up_q, second_tuning_capacitor_dn_q;
    logic       bus_address_valid_q, power_on_monitor_o_q, power_on_monitor_oe_n_q;
    tmpc_pkg::tmpc_mode_e mode_q;
    int         failures = 0, checks_done = 0;

    always #25 clk = ~clk;

    tmpc_top        uut (.*);
    tmpc_mech_model mech (.*);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // checks land on the falling edge, clear of the registers' updates
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic wait_goal;
        int i;
        settle(4);
        for (i = 0; i < 1000 && capacitors_at_goal_q !== 1'b1; i++) @(negedge clk);
        if (i == 1000) begin
            failures++;
            end_sim();
        end
    endtask : wait_goal

    task automatic rf_on_expect_start;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        rf_detected <= 1'b1;
        repeat (4) begin
            @(negedge clk);
            if (tune_start_q === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
    endtask : rf_on_expect_start

    task automatic t_local;
        @(posedge clk);
        tune_select_open                <= 1'b0;
        first_tuning_capacitor_setpoint <= 7'h32;
        preset_write                    <= 1'b1;
        preset_write_index              <= 4'h3;
        preset_write_c1                 <= 7'h14;
        preset_write_c2                 <= 7'h1E;
        @(posedge clk);
        preset_write        <= 1'b0;
        panel_preset_select <= 4'h3;
        settle(3);
        chk(mode_q, tmpc_pkg::TMPC_MODE_LOCAL);
        chk(first_tuning_capacitor_goal_q, 8'h00);
        chk(bus_address_q, 8'h05);
        chk(bus_address_valid_q, 1'b1);
    endtask : t_local

    task automatic t_manual;
        @(posedge clk);
        local_remote_button              <= 1'b1;
        second_tuning_capacitor_setpoint <= 7'h78;
        @(posedge clk);
        local_remote_button <= 1'b0;
        panel_preset_select <= 4'h7;
        wait_goal();
        chk(remote_active_q, 1'b1);
        chk(mode_q, tmpc_pkg::TMPC_MODE_REM_MAN);
        chk(second_tuning_capacitor_goal_q, 8'h63);
        chk(first_tuning_capacitor_report_q, 8'h32);
        chk(second_tuning_capacitor_report_q, 8'h63);
    endtask : t_manual

    task automatic t_rem_auto;
        @(posedge clk);
        tune_select_open <= 1'b1;
        wait_goal();
        chk(mode_q, tmpc_pkg::TMPC_MODE_REM_AUTO);
        chk(first_tuning_capacitor_report_q, 8'h14);
        chk(second_tuning_capacitor_report_q, 8'h1E);
        rf_on_expect_start();
        chk(tune_active_q, 1'b1);
        @(posedge clk);
        tune_done   <= 1'b1;
        rf_detected <= 1'b0;
        @(posedge clk);
        tune_done <= 1'b0;
    endtask : t_rem_auto

    task automatic t_auto_ctl;
        int c;
        @(posedge clk);
        config_switch_12    <= 1'b1;
        config_switches_1_4 <= 4'hA;
        tune_select_open    <= 1'b0;
        wait_goal();
        chk(mode_q, tmpc_pkg::TMPC_MODE_AUTO_CTL);
        chk(bus_address_valid_q, 1'b0);
        chk(first_tuning_capacitor_position, 8'h63);
        chk(second_tuning_capacitor_position, 8'h63);
        rf_on_expect_start();
        @(posedge clk);
        config_switches_1_4 <= 4'h3;
        settle(3);
        @(posedge clk);
        rf_detected <= 1'b0;
        wait_goal();
        chk(first_tuning_capacitor_position, 8'h14);
        chk(second_tuning_capacitor_position, 8'h1E);
        // hold must return to where RF dropped (full mesh), not to preset 3
        @(posedge clk);
        config_switches_1_4 <= 4'hB;
        wait_goal();
        chk(first_tuning_capacitor_goal_q, 8'h63);
        chk(second_tuning_capacitor_goal_q, 8'h63);
        for (c = 9; c < 16; c++) begin
            @(posedge clk);
            config_switches_1_4 <= c[3:0];
            settle(3);
            chk(preset_invalid_q, c > 11);
        end
        @(posedge clk);
        config_switch_12 <= 1'b0;
        settle(2);
        chk(bus_address_q, 8'h0F);
    endtask : t_auto_ctl

    task automatic t_command;
        @(posedge clk);
        local_remote_button <= 1'b1;
        @(posedge clk);
        local_remote_button <= 1'b0;
        settle(2);
        chk(remote_active_q, 1'b0);
        chk(mode_q, tmpc_pkg::TMPC_MODE_LOCAL);
        @(posedge clk);
        remote_mode_command <= 1'b1;
        @(posedge clk);
        remote_mode_command <= 1'b0;
        settle(2);
        chk(remote_active_q, 1'b1);
        chk(mode_q, tmpc_pkg::TMPC_MODE_REM_MAN);
    endtask : t_command

    initial begin
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk(power_on_monitor_oe_n_q, 1'b0);
        @(posedge clk);
        reset_n <= 1'b1;
        t_local();
        t_manual();
        t_rem_auto();
        t_auto_ctl();
        t_command();
        chk(power_on_monitor_oe_n_q, 1'b0);
        chk(power_on_monitor_o_q, 1'b0);
        end_sim();
    end
endmodule : tmpc_top_tb_top
